//--- hdl/adbr_pkg.sv
// constants and carrier types for the right-agc decay, adc path and bypass registers
// assumes a byte-wide register port already decoded from the control bus, one clock
//
// Functional notes
// - decay bit 7 low takes decay from register 29, high from own fields.
// - baseline code 00..11 gives 50, 150, 250, 350 ms decay.
// - multiplier field scales baseline by two to the field value, 1 to 128.
// - decay is capped by decimation ratio, 4 s at 1 up to 22.4 s.
// - bits 7 and 6 pick default or programmable high-pass coefficients, left/right.
// - field 5..4 picks digital or analog microphone per channel.
// - bit 3 attaches programmable filter to adc output only while both dacs down.
// - bit 2 low enables bus error detection and clearing; high disables it.
// - status bit 0 shows a detected bus error and clears when read.
// - bits 7..4 close right-side bypass switches onto right line outputs.
// - bits 3..0 close left-side bypass switches onto left line outputs.
package adbr_pkg;

  // register offsets
  localparam logic [6:0] DECAY_OFS  = 7'h6A;
  localparam logic [6:0] PATH_OFS   = 7'h6B;
  localparam logic [6:0] BYPASS_OFS = 7'h6C;

  // values after reset
  localparam logic [7:0] DECAY_RST  = 8'h00;
  localparam logic [7:0] PATH_RST   = 8'h00;
  localparam logic [7:0] BYPASS_RST = 8'h00;

  // field positions
  localparam int DECAY_SRC_BIT   = 7;
  localparam int DECAY_BASE_LSB  = 5;
  localparam int DECAY_MULT_LSB  = 2;
  localparam int HPF_LEFT_BIT    = 7;
  localparam int HPF_RIGHT_BIT   = 6;
  localparam int MIC_LSB         = 4;
  localparam int PROG_FILT_BIT   = 3;
  localparam int DET_DIS_BIT     = 2;
  localparam int ERR_STS_BIT     = 0;

  // baseline decay times in ms
  localparam logic [15:0] BASE_MS_STEP = 16'h0064;  // 100 ms between codes
  localparam logic [15:0] BASE_MS_MIN  = 16'h0032;  // 50 ms

  // decay ceilings in ms, indexed by decimation ratio in half steps
  localparam logic [15:0] LIM_1_MS   = 16'h0FA0;  // 4 s
  localparam logic [15:0] LIM_1P5_MS = 16'h15E0;  // 5.6 s
  localparam logic [15:0] LIM_2_MS   = 16'h1F40;  // 8 s
  localparam logic [15:0] LIM_2P5_MS = 16'h2580;  // 9.6 s
  localparam logic [15:0] LIM_3_MS   = 16'h2BC0;  // 11.2 s
  localparam logic [15:0] LIM_4_MS   = 16'h3E80;  // 16 s
  localparam logic [15:0] LIM_5_MS   = 16'h4B00;  // 19.2 s
  localparam logic [15:0] LIM_5P5_MS = 16'h5780;  // 22.4 s

  // one register access, at most one of wr and rd per cycle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } adbr_req_s;

  // microphone type per channel
  typedef enum logic [1:0] {
    ADBR_MIC_DIG_DIG = 2'b00,
    ADBR_MIC_DIG_ANA = 2'b01,
    ADBR_MIC_ANA_DIG = 2'b10,
    ADBR_MIC_ANA_ANA = 2'b11
  } adbr_mic_e;

endpackage : adbr_pkg

//--- hdl/adbr_regs.sv
// register bank: right-agc decay, adc digital path with bus error status, bypass switches
// assumes req comes from the control-bus engine on sys_clk; all inputs are on sys_clk
module adbr_regs #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // register port
  input  wire adbr_pkg::adbr_req_s req,
  output logic [DATA_W-1:0]      rd_data,
  output logic                   rd_valid,
  // agc decay
  input  wire logic [15:0]       legacy_decay_ms,
  input  wire logic [3:0]        adc_decimation_ratio,
  output logic [15:0]            right_agc_decay_ms,
  // adc path
  input  wire logic              left_dac_powered,
  input  wire logic              right_dac_powered,
  output logic                   hpf_left_prog,
  output logic                   hpf_right_prog,
  output adbr_pkg::adbr_mic_e    mic_type,
  output logic                   prog_filter_on_adc,
  // bus condition
  input  wire logic              bus_error_event,
  output logic                   bus_error_clear,
  // bypass switches
  output logic                   second_right_minus_input,
  output logic                   second_right_plus_input,
  output logic                   first_right_minus_input,
  output logic                   first_right_plus_input,
  output logic                   second_left_minus_input,
  output logic                   second_left_plus_input,
  output logic                   first_left_minus_input,
  output logic                   first_left_plus_input
);

  if (DATA_W != 8) begin : g_width_check
    $error("adbr_regs serves 8-bit registers only");
  end

  logic [7:0]  decay_reg;
  logic [7:0]  path_reg;
  logic [7:0]  bypass_reg;
  logic        err_sts_reg;
  logic [15:0] decay_next;
  logic        err_evt;
  logic        wr_decay;
  logic        wr_path;
  logic        wr_bypass;
  logic        rd_path;

  // ceiling for a decimation ratio given in half steps; unknown codes take the lowest cap
  function automatic logic [15:0] decay_limit(input logic [3:0] half_ratio);
    unique case (half_ratio)
      4'h3:        decay_limit = adbr_pkg::LIM_1P5_MS;
      4'h4:        decay_limit = adbr_pkg::LIM_2_MS;
      4'h5:        decay_limit = adbr_pkg::LIM_2P5_MS;
      4'h6, 4'h7:  decay_limit = adbr_pkg::LIM_3_MS;
      4'h8, 4'h9:  decay_limit = adbr_pkg::LIM_4_MS;
      4'hA:        decay_limit = adbr_pkg::LIM_5_MS;
      4'hB, 4'hC:  decay_limit = adbr_pkg::LIM_5P5_MS;
      default:     decay_limit = adbr_pkg::LIM_1_MS;
    endcase
  endfunction : decay_limit

  ////////////////////////////////////////////////////////////////////////////
  // access decode
  assign wr_decay  = req.wr && (req.addr == adbr_pkg::DECAY_OFS);
  assign wr_path   = req.wr && (req.addr == adbr_pkg::PATH_OFS);
  assign wr_bypass = req.wr && (req.addr == adbr_pkg::BYPASS_OFS);
  assign rd_path   = req.rd && (req.addr == adbr_pkg::PATH_OFS);
  assign err_evt   = bus_error_event && !path_reg[adbr_pkg::DET_DIS_BIT];

  // decay register; reserved low bits kept as written, host keeps them zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      decay_reg <= adbr_pkg::DECAY_RST;
    end else if (wr_decay) begin
      decay_reg <= req.wdata;
    end
  end

  // path register; bit 1 is read-only zero, bit 0 lives in err_sts_reg
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      path_reg <= adbr_pkg::PATH_RST;
    end else if (wr_path) begin
      path_reg <= {req.wdata[7:2], 2'b00};
    end
  end

  // bypass switch register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bypass_reg <= adbr_pkg::BYPASS_RST;
    end else if (wr_bypass) begin
      bypass_reg <= req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky bus error; a new event beats the read-clear so nothing is lost
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      err_sts_reg <= 1'b0;
    end else if (err_evt) begin
      err_sts_reg <= 1'b1;
    end else if (rd_path) begin
      err_sts_reg <= 1'b0;
    end
  end

  // recovery pulse to the bus engine, only while detection is enabled
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_error_clear <= 1'b0;
    end else begin
      bus_error_clear <= err_evt;
    end
  end

  // read data captured from the pre-clear status; unmapped offsets read zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= req.rd;
      if (req.rd) begin
        unique case (req.addr)
          adbr_pkg::DECAY_OFS:  rd_data <= decay_reg;
          adbr_pkg::PATH_OFS:   rd_data <= {path_reg[7:1], err_sts_reg};
          adbr_pkg::BYPASS_OFS: rd_data <= bypass_reg;
          default:              rd_data <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective decay time; 350 ms x 128 still fits 16 bits
  always_comb begin
    logic [15:0] base_ms;
    logic [15:0] raw_ms;
    logic [15:0] lim_ms;
    base_ms = adbr_pkg::BASE_MS_MIN
            + 16'(decay_reg[adbr_pkg::DECAY_BASE_LSB +: 2]) * adbr_pkg::BASE_MS_STEP;
    raw_ms  = decay_reg[adbr_pkg::DECAY_SRC_BIT] ?
              16'(base_ms << decay_reg[adbr_pkg::DECAY_MULT_LSB +: 3]) :
              legacy_decay_ms;
    lim_ms  = decay_limit(adc_decimation_ratio);
    decay_next = (raw_ms > lim_ms) ? lim_ms : raw_ms;
  end

  // path outputs registered; filter follows dac power each cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      right_agc_decay_ms <= 16'h0000;
      prog_filter_on_adc <= 1'b0;
    end else begin
      right_agc_decay_ms <= decay_next;
      prog_filter_on_adc <= path_reg[adbr_pkg::PROG_FILT_BIT]
                            && !left_dac_powered && !right_dac_powered;
    end
  end

  // static settings driven straight from their flops
  assign hpf_left_prog  = path_reg[adbr_pkg::HPF_LEFT_BIT];
  assign hpf_right_prog = path_reg[adbr_pkg::HPF_RIGHT_BIT];
  assign mic_type       = adbr_pkg::adbr_mic_e'(path_reg[adbr_pkg::MIC_LSB +: 2]);
  // switch closures; shorting two inputs is the host's to avoid
  assign {second_right_minus_input, second_right_plus_input,
          first_right_minus_input,  first_right_plus_input} = bypass_reg[7:4];
  assign {second_left_minus_input,  second_left_plus_input,
          first_left_minus_input,   first_left_plus_input}  = bypass_reg[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_DECAY_CAP: assert property (
    right_agc_decay_ms <= decay_limit($past(adc_decimation_ratio)))
    else $error("decay exceeds ratio ceiling");
  AST_DECAY_MIN: assert property (
    (wr_decay && req.wdata == 8'h80) ##1 !req.wr |=> right_agc_decay_ms == 16'h0032)
    else $error("baseline 50 ms not produced");
  AST_DECAY_MAX: assert property (
    (wr_decay && req.wdata == 8'hFC) ##1 (!req.wr && adc_decimation_ratio == 4'hC)
    |=> right_agc_decay_ms == adbr_pkg::LIM_5P5_MS)
    else $error("x128 decay not capped to 22.4 s");
  AST_DECAY_LEGACY: assert property (
    (!decay_reg[7] && legacy_decay_ms <= decay_limit(adc_decimation_ratio))
    |=> right_agc_decay_ms == $past(legacy_decay_ms))
    else $error("legacy decay not followed");
  AST_PATH_FIELDS: assert property (
    wr_path |=> {hpf_left_prog, hpf_right_prog, mic_type} == $past(req.wdata[7:4]))
    else $error("path fields not stored");
  AST_PROG_FILT: assert property (
    prog_filter_on_adc |-> $past(!left_dac_powered && !right_dac_powered && path_reg[3]))
    else $error("filter attached with a dac powered");
  AST_ERR_SET: assert property (
    err_evt |=> err_sts_reg && bus_error_clear)
    else $error("enabled error not recorded");
  AST_ERR_MASK: assert property (
    (bus_error_event && path_reg[2] && !err_sts_reg) |=> !err_sts_reg && !bus_error_clear)
    else $error("disabled detector reacted");
  AST_RD_CLEAR: assert property (
    (rd_path && !err_evt) |=> !err_sts_reg && rd_valid && rd_data[0] == $past(err_sts_reg))
    else $error("read-clear wrong");
  AST_RD_RACE: assert property (
    (rd_path && err_evt) |=> err_sts_reg && rd_valid && rd_data[0] == $past(err_sts_reg))
    else $error("error during read lost");
  AST_BYPASS: assert property (
    wr_bypass |=> {second_right_minus_input, second_right_plus_input,
                   first_right_minus_input,  first_right_plus_input} == $past(req.wdata[7:4]))
    else $error("right bypass switch mismatch");
  AST_BYPASS_LEFT: assert property (
    wr_bypass |=> {second_left_minus_input, second_left_plus_input,
                   first_left_minus_input,  first_left_plus_input} == $past(req.wdata[3:0]))
    else $error("left bypass switch mismatch");
  AST_RSVD_BIT: assert property (
    rd_valid && $past(rd_path) |-> rd_data[1] == 1'b0)
    else $error("reserved bit reads one");

  COV_ERR_READ:  cover property (err_evt ##[1:4] rd_path);
  COV_RACE:      cover property (rd_path && err_evt);
  COV_CAPPED:    cover property (decay_reg[7] && right_agc_decay_ms == adbr_pkg::LIM_1_MS);
  COV_FILT:      cover property ($rose(prog_filter_on_adc));

endmodule : adbr_regs

//--- testbench/adbr_host.sv
// host controller model: byte writes and reads on the register port
// assumes sys_clk from the bench; drives req just after falling edges
module adbr_host (
  // clock
  input  wire logic           sys_clk,
  // register port
  output adbr_pkg::adbr_req_s req,
  input  wire logic [7:0]     rd_data,
  input  wire logic           rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle port from time zero
  initial req = '0;

  //////////////////////////////////////////////////////////////////////////////
  // one write; reserved bits zeroed, a first input that would short is dropped
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] w;
    w = d;
    if (a == adbr_pkg::DECAY_OFS) w[1:0] = 2'h0;
    if (a == adbr_pkg::PATH_OFS) w[1:0] = 2'h0;
    if (a == adbr_pkg::BYPASS_OFS) begin
      w[5:4] = w[5:4] & ~w[7:6];
      w[1:0] = w[1:0] & ~w[3:2];
    end
    @(negedge sys_clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
    @(negedge sys_clk);
    req = '0;
  endtask : wr_reg

  // one read; rd_valid stands only in the cycle after the taking edge, so look there
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(negedge sys_clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    v = rd_valid;
    d = rd_data;
    req = '0;
  endtask : rd_reg
endmodule : adbr_host

//--- testbench/agc_decay_adc_path_bypass_regs_bench.sv
// self-checking bench for the decay, adc path and bypass register bank
// assumes adbr_regs and adbr_host; inputs change on falling edges only
module agc_decay_adc_path_bypass_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                sys_clk, rst, v, hl, hr, pf, bus_error_clear;
  logic                left_dac_powered, right_dac_powered, bus_error_event;
  logic [15:0]         legacy_decay_ms, decay_ms;
  logic [3:0]          adc_decimation_ratio;
  logic [7:0]          rd_data, d, sw;
  logic [1:0]          kk;
  logic                rd_valid;
  adbr_pkg::adbr_req_s req;
  adbr_pkg::adbr_mic_e mic_type;
  int                  n_mismatch = 0;
  int                  n_compared = 0;

  adbr_host host (.sys_clk(sys_clk), .req(req), .rd_data(rd_data), .rd_valid(rd_valid));

  adbr_regs #(.DATA_W(8)) uut (
    .sys_clk(sys_clk), .rst(rst), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
    .legacy_decay_ms(legacy_decay_ms), .adc_decimation_ratio(adc_decimation_ratio),
    .right_agc_decay_ms(decay_ms), .left_dac_powered(left_dac_powered),
    .right_dac_powered(right_dac_powered), .hpf_left_prog(hl), .hpf_right_prog(hr),
    .mic_type(mic_type), .prog_filter_on_adc(pf), .bus_error_event(bus_error_event),
    .bus_error_clear(bus_error_clear), .second_right_minus_input(sw[7]),
    .second_right_plus_input(sw[6]), .first_right_minus_input(sw[5]),
    .first_right_plus_input(sw[4]), .second_left_minus_input(sw[3]),
    .second_left_plus_input(sw[2]), .first_left_minus_input(sw[1]),
    .first_left_plus_input(sw[0]));

  //////////////////////////////////////////////////////////////////////////////
  // ceiling per ratio code, half steps; unlisted codes fall back to 4 s
  function automatic logic [15:0] cap_ms(input logic [3:0] r);
    case (r)
      4'h3:       cap_ms = 16'h15E0;
      4'h4:       cap_ms = 16'h1F40;
      4'h5:       cap_ms = 16'h2580;
      4'h6, 4'h7: cap_ms = 16'h2BC0;
      4'h8, 4'h9: cap_ms = 16'h3E80;
      4'hA:       cap_ms = 16'h4B00;
      4'hB, 4'hC: cap_ms = 16'h5780;
      default:    cap_ms = 16'h0FA0;
    endcase
  endfunction : cap_ms

  // own-field decay, clamped; 32 bits so 350 ms x 128 does not wrap
  function automatic logic [15:0] exp_ms(input int b, input int m, input logic [3:0] r);
    logic [31:0] t;
    t = (32'h32 + 32'h64 * b) << m;
    exp_ms = (t > 32'(cap_ms(r))) ? cap_ms(r) : t[15:0];
  endfunction : exp_ms

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic final_report;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  //////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock and watchdog well past the few hundred cycles used
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #100us;
    n_mismatch++;
    final_report();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    {left_dac_powered, right_dac_powered, bus_error_event} = 3'h6;
    legacy_decay_ms = 16'h1234;
    adc_decimation_ratio = 4'hC;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    host.wr_reg(7'h6D, 8'hFF);  // unmapped, must be ignored
    for (int a = 8'h6A; a <= 8'h6D; a++) begin
      host.rd_reg(7'(a), d, v);
      chk("rd_valid", 16'h0001, 16'(v));
      chk("reset_rd", 16'h0000, 16'(d));
    end
    host.wr_reg(adbr_pkg::DECAY_OFS, 8'h7F);
    repeat (2) @(negedge sys_clk);
    chk("decay", 16'h1234, decay_ms);
    for (int b = 0; b < 4; b++)
      for (int m = 0; m < 8; m++) begin
        host.wr_reg(adbr_pkg::DECAY_OFS, {1'b1, 2'(b), 3'(m), 2'h3});
        repeat (2) @(negedge sys_clk);
        chk("decay", exp_ms(b, m, 4'hC), decay_ms);
      end
    for (int r = 0; r < 16; r++) begin
      adc_decimation_ratio = 4'(r);
      repeat (2) @(negedge sys_clk);
      chk("cap", cap_ms(4'(r)), decay_ms);
    end
    // legacy source is clamped as well; last ratio code caps at 4 s
    host.wr_reg(adbr_pkg::DECAY_OFS, 8'h00);
    repeat (2) @(negedge sys_clk);
    chk("decay", 16'h0FA0, decay_ms);
    // path fields, every microphone code
    for (int k = 0; k < 4; k++) begin
      kk = 2'(k);
      host.wr_reg(adbr_pkg::PATH_OFS, {kk[0], ~kk[0], kk, 4'hF});
      @(negedge sys_clk);
      chk("hpf_l", 16'(kk[0]), 16'(hl));
      chk("hpf_r", 16'(!kk[0]), 16'(hr));
      chk("mic", 16'(kk), 16'(mic_type));
      chk("pfilt", 16'h0000, 16'(pf));
      host.rd_reg(adbr_pkg::PATH_OFS, d, v);
      chk("path_rd", 16'({kk[0], ~kk[0], kk, 4'hC}), 16'(d));
    end
    left_dac_powered = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("pfilt", 16'h0000, 16'(pf));
    right_dac_powered = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("pfilt", 16'h0001, 16'(pf));
    host.wr_reg(adbr_pkg::PATH_OFS, 8'h00);
    @(negedge sys_clk);
    chk("pfilt", 16'h0000, 16'(pf));
    // bus error seen, reported once, cleared by the read
    bus_error_event = 1'b1;
    @(negedge sys_clk);
    bus_error_event = 1'b0;
    chk("err_clear", 16'h0001, 16'(bus_error_clear));
    host.rd_reg(adbr_pkg::PATH_OFS, d, v);
    chk("status", 16'h0001, 16'(d));
    host.rd_reg(adbr_pkg::PATH_OFS, d, v);
    chk("status", 16'h0000, 16'(d));
    // error landing in the same cycle as the read must survive it
    fork
      host.rd_reg(adbr_pkg::PATH_OFS, d, v);
      begin
        @(negedge sys_clk);
        bus_error_event = 1'b1;
        @(negedge sys_clk);
        bus_error_event = 1'b0;
      end
    join
    chk("status", 16'h0000, 16'(d));
    host.rd_reg(adbr_pkg::PATH_OFS, d, v);
    chk("status", 16'h0001, 16'(d));
    host.wr_reg(adbr_pkg::PATH_OFS, 8'h04);
    bus_error_event = 1'b1;
    @(negedge sys_clk);
    bus_error_event = 1'b0;
    chk("err_clear", 16'h0000, 16'(bus_error_clear));
    host.rd_reg(adbr_pkg::PATH_OFS, d, v);
    chk("status", 16'h0004, 16'(d));
    // bypass switches one at a time, then everything asked at once
    for (int i = 0; i < 8; i++) begin
      host.wr_reg(adbr_pkg::BYPASS_OFS, 8'h01 << i);
      @(negedge sys_clk);
      chk("switch", 16'h0001 << i, 16'(sw));
      host.rd_reg(adbr_pkg::BYPASS_OFS, d, v);
      chk("bypass_rd", 16'h0001 << i, 16'(d));
    end
    host.wr_reg(adbr_pkg::BYPASS_OFS, 8'hFF);
    @(negedge sys_clk);
    chk("switch", 16'h00CC, 16'(sw));
    final_report();
  end
endmodule : agc_decay_adc_path_bypass_regs_bench
